// ---- logic/event_timer.sv ----
// down counter that flags when it has run out
// assumes load is a level from the same clock domain
`timescale 1ns/1ps
module event_timer #(
  parameter int W = 8,
  parameter logic [W-1:0] START = '0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;

  // reload while load is high, otherwise count down and stick at zero
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_val;
    end else if (count != '0) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= START;
    end else begin
      count <= next_count;
    end
  end

  assign done = (count == '0);
endmodule : event_timer

// ---- logic/link_sync.sv ----
// two-flop synchroniser for levels entering the core clock domain
// assumes the reset given is already synchronous in its release
`timescale 1ns/1ps
module link_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : link_sync

// ---- logic/mgmt_ctrl.sv ----
// management control and status logic of an optical transceiver module
// assumes a host on the 2-wire bus and control pins, and local firmware
// on a classic wishbone bus reporting live fault conditions
`timescale 1ns/1ps
// Operation
// - fully working within 2000 ms of power-on, hot plug or reset release
// - reset pin low counts only when longer than 2 us
// - answer the 2-wire bus within 2000 ms of power-on
// - within 2000 ms clear data-not-ready (byte 2 bit 0), assert interrupt
// - ready is signalled by interrupt due to data-not-ready clearing
// - low-power pin high reaches low power within 100 us
// - interrupt output goes low within 200 ms of a trigger
// - flags clear on read; interrupt released within 500 us after
// - rx loss-of-signal sets its flag and interrupt within 100 ms
// - any flag condition sets its flag and interrupt within 200 ms
// - mask bit set stops its flag driving interrupt within 100 ms
// - mask bit cleared resumes its flag's interrupt within 100 ms
// - module select asserted: answer the bus within 100 us
// - module select released: stop answering the bus within 100 us
// - power-down bit set reaches low power within 100 ms
// - power-down bit cleared: fully functional again within 300 ms
// - write delays count from the end of the write transaction
// - clear-on-read delays count from the end of the read
// - memory answers at address A0h; lower page of 128 bytes
module mgmt_ctrl #(
  parameter int INIT_CYCLES = mgmt_pkg::INIT_CYCLES
) (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // module control pins from the host
  input wire logic MODULE_RESET_N,
  input wire logic MODULE_SELECT_N,
  input wire logic LOW_POWER_REQUEST,
  output logic MODULE_PRESENT_N,
  output logic INTERRUPT_N,
  // power level control
  output logic LOW_POWER_MODE,
  // 2-wire management bus
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE,
  // wishbone slave for local firmware
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [mgmt_pkg::ADR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);
  import mgmt_pkg::*;

  typedef struct packed {
    i2c_state_t st;
    logic scl_q;
    logic sda_q;
    logic [7:0] shift;
    logic [3:0] bitn;
    logic [7:0] ptr;
    logic rd;
    logic first;
    logic sda_oe;
    logic [7:0] pend_mask;
    logic pend_mask_v;
    logic pend_pdown;
    logic pend_pdown_v;
    logic [7:0] pend_clr;
    logic pend_clr_ready;
    logic in_reset;
    logic not_ready;
    logic ready_evt;
    logic data_valid;
    logic [7:0] cond;
    logic [7:0] flags;
    logic [7:0] mask;
    logic pdown;
    logic int_n;
    logic low_power;
    logic wb_ack;
    logic [31:0] wb_dat;
  } state_t;

  localparam state_t S_RESET = '{st: I2C_IDLE, not_ready: 1'b1,
    int_n: 1'b1, default: '0};

  state_t s;
  state_t next_s;
  logic rst_sync;
  logic [4:0] pins_s;
  logic mod_rst_n_s;
  logic sel_n_s;
  logic lp_s;
  logic scl_s;
  logic sda_s;
  logic pulse_done;
  logic init_done;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;
  logic active;

  // reset release and pin synchronisers
  link_sync #(.W(1)) u_rst_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .d(1'b1),
    .q(rst_sync)
  );

  link_sync #(.W(5)) u_pin_sync (
    .clk(CORE_CLK),
    .rst_n(rst_sync),
    .d({MODULE_RESET_N, MODULE_SELECT_N, LOW_POWER_REQUEST, SCL, SDA_IN}),
    .q(pins_s)
  );

  assign mod_rst_n_s = pins_s[4];
  assign sel_n_s = pins_s[3];
  assign lp_s = pins_s[2];
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  // reset pin glitch filter: runs out only after a long enough low
  event_timer #(.W(PULSE_W), .START(PULSE_W'(RESET_PULSE_CYCLES)))
  u_pulse (
    .clk(CORE_CLK),
    .rst_n(rst_sync),
    .load(mod_rst_n_s),
    .load_val(PULSE_W'(RESET_PULSE_CYCLES)),
    .done(pulse_done)
  );

  // deadline for monitor data after power-on or module reset
  event_timer #(.W(INIT_W), .START(INIT_W'(INIT_CYCLES - 1))) u_init (
    .clk(CORE_CLK),
    .rst_n(rst_sync),
    .load(s.in_reset),
    .load_val(INIT_W'(INIT_CYCLES - 1)),
    .done(init_done)
  );

  // bus events seen on the synchronised lines
  assign start_ev = s.scl_q & scl_s & s.sda_q & ~sda_s;
  assign stop_ev = s.scl_q & scl_s & ~s.sda_q & sda_s;
  assign rise_ev = ~s.scl_q & scl_s;
  assign fall_ev = s.scl_q & ~scl_s;
  assign active = ~sel_n_s & ~s.in_reset;

  // byte that the host sees at the current pointer
  function automatic logic [7:0] page_byte(input state_t c);
    logic [7:0] b;
    b = 8'h00;
    case (c.ptr)
      PAGE_STATUS: b[NOT_READY_BIT] = c.not_ready;
      PAGE_FLAGS: b = c.flags;
      PAGE_CTRL: b[PDOWN_BIT] = c.pdown;
      PAGE_MASK: b = c.mask;
      default: b = 8'h00;
    endcase
    return b;
  endfunction : page_byte

  // next state of the whole block
  always_comb begin
    logic [7:0] rd_byte;
    logic load_rd;
    logic wb_req;
    rd_byte = page_byte(s);
    load_rd = 1'b0;
    wb_req = WB_CYC_I & WB_STB_I & ~s.wb_ack;
    next_s = s;
    next_s.scl_q = scl_s;
    next_s.sda_q = sda_s;

    // module reset pin, filtered for short glitches
    if (!mod_rst_n_s && pulse_done) begin
      next_s.in_reset = 1'b1;
    end else if (mod_rst_n_s) begin
      next_s.in_reset = 1'b0;
    end

    // 2-wire slave; deselect forces it idle and off the bus
    if (!active) begin
      next_s.st = I2C_IDLE;
      next_s.sda_oe = 1'b0;
    end else if (start_ev) begin
      next_s.st = I2C_ADDR;
      next_s.bitn = '0;
      next_s.sda_oe = 1'b0;
      next_s.pend_mask_v = 1'b0;
      next_s.pend_pdown_v = 1'b0;
      next_s.pend_clr = '0;
      next_s.pend_clr_ready = 1'b0;
    end else if (stop_ev) begin
      // writes and clear-on-read land only at the stop
      next_s.st = I2C_IDLE;
      next_s.sda_oe = 1'b0;
      if (s.pend_mask_v) begin
        next_s.mask = s.pend_mask;
      end
      if (s.pend_pdown_v) begin
        next_s.pdown = s.pend_pdown;
      end
      next_s.flags = s.flags & ~s.pend_clr;
      if (s.pend_clr_ready) begin
        next_s.ready_evt = 1'b0;
      end
      next_s.pend_mask_v = 1'b0;
      next_s.pend_pdown_v = 1'b0;
      next_s.pend_clr = '0;
      next_s.pend_clr_ready = 1'b0;
    end else begin
      unique case (s.st)
        I2C_IDLE: begin
        end
        I2C_ADDR: begin
          if (rise_ev) begin
            next_s.shift = {s.shift[6:0], sda_s};
            next_s.bitn = s.bitn + 4'h1;
          end else if (fall_ev && s.bitn == BIT_LAST) begin
            if (s.shift[7:1] == DEV_ADDR) begin
              next_s.st = I2C_ADDR_ACK;
              next_s.sda_oe = 1'b1;
              next_s.rd = s.shift[0];
            end else begin
              next_s.st = I2C_IDLE;
            end
          end
        end
        I2C_ADDR_ACK: begin
          if (fall_ev) begin
            next_s.bitn = '0;
            next_s.sda_oe = 1'b0;
            if (s.rd) begin
              load_rd = 1'b1;
            end else begin
              next_s.st = I2C_WDATA;
              next_s.first = 1'b1;
            end
          end
        end
        I2C_WDATA: begin
          if (rise_ev) begin
            next_s.shift = {s.shift[6:0], sda_s};
            next_s.bitn = s.bitn + 4'h1;
          end else if (fall_ev && s.bitn == BIT_LAST) begin
            next_s.st = I2C_WACK;
            next_s.sda_oe = 1'b1;
            if (s.first) begin
              next_s.ptr = s.shift; // first byte sets the pointer
              next_s.first = 1'b0;
            end else begin
              if (s.ptr == PAGE_MASK) begin
                next_s.pend_mask = s.shift;
                next_s.pend_mask_v = 1'b1;
              end
              if (s.ptr == PAGE_CTRL) begin
                next_s.pend_pdown = s.shift[PDOWN_BIT];
                next_s.pend_pdown_v = 1'b1;
              end
              next_s.ptr = s.ptr + 8'h01;
            end
          end
        end
        I2C_WACK: begin
          if (fall_ev) begin
            next_s.st = I2C_WDATA;
            next_s.sda_oe = 1'b0;
            next_s.bitn = '0;
          end
        end
        I2C_RDATA: begin
          if (rise_ev) begin
            next_s.bitn = s.bitn + 4'h1;
          end else if (fall_ev) begin
            if (s.bitn == BIT_LAST) begin
              next_s.st = I2C_RACK;
              next_s.sda_oe = 1'b0;
            end else begin
              next_s.shift = {s.shift[6:0], 1'b0};
              next_s.sda_oe = ~s.shift[6]; // open drain: drive zeros only
            end
          end
        end
        I2C_RACK: begin
          if (rise_ev && sda_s) begin
            next_s.st = I2C_IDLE; // host nack ends the read
          end else if (fall_ev) begin
            next_s.bitn = '0;
            load_rd = 1'b1;
          end
        end
        default: next_s.st = I2C_IDLE;
      endcase
    end

    // load a byte for the host and note what must clear on read
    if (load_rd) begin
      next_s.st = I2C_RDATA;
      next_s.shift = rd_byte;
      next_s.sda_oe = ~rd_byte[7];
      next_s.ptr = s.ptr + 8'h01;
      if (s.ptr == PAGE_FLAGS) begin
        next_s.pend_clr = s.pend_clr | rd_byte;
      end
      if (s.ptr == PAGE_STATUS) begin
        next_s.pend_clr_ready = 1'b1;
      end
    end

    // wishbone slave: one wait state, unmapped reads return zero
    next_s.wb_ack = wb_req;
    if (wb_req) begin
      if (WB_WE_I && WB_SEL_I[0]) begin
        case (WB_ADR_I)
          WB_COND: next_s.cond = WB_DAT_I[7:0];
          WB_CTRL: next_s.data_valid = WB_DAT_I[0];
          default: begin
          end
        endcase
      end
      case (WB_ADR_I)
        WB_COND: next_s.wb_dat = {24'h000000, s.cond};
        WB_CTRL: next_s.wb_dat = {31'h0, s.data_valid};
        WB_STATUS: next_s.wb_dat = {8'h00, s.mask, s.flags, 2'h0,
          s.in_reset, s.pdown, ~sel_n_s, s.low_power, s.int_n,
          s.not_ready};
        default: next_s.wb_dat = 32'h00000000;
      endcase
    end

    // live conditions set flags after the clear on read, so a set wins over it; module reset still clears them
    // masking is applied only at the interrupt, never here
    next_s.flags = next_s.flags | s.cond;

    // ready once monitor data is valid, or at the latest at the deadline
    if (s.not_ready && (s.data_valid || init_done) && !s.in_reset) begin
      next_s.not_ready = 1'b0;
      next_s.ready_evt = 1'b1;
    end

    // module reset restarts initialisation from scratch
    if (s.in_reset) begin
      next_s.not_ready = 1'b1;
      next_s.ready_evt = 1'b0;
      next_s.data_valid = 1'b0;
      next_s.flags = '0;
      next_s.mask = '0;
      next_s.pdown = 1'b0;
    end

    // outputs follow the new state in the same edge, well inside limits
    next_s.int_n = ~(next_s.ready_evt |
      (|(next_s.flags & ~next_s.mask)));
    next_s.low_power = lp_s | next_s.pdown;
  end

  always_ff @(posedge CORE_CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      s <= S_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs; module present is strapped low
  assign MODULE_PRESENT_N = 1'b0;
  assign INTERRUPT_N = s.int_n;
  assign LOW_POWER_MODE = s.low_power;
  assign SDA_OUT = 1'b0;
  assign SDA_OE = s.sda_oe;
  assign WB_DAT_O = s.wb_dat;
  assign WB_ACK_O = s.wb_ack;

  // helper counters read only by the checks below
  localparam int RST_MIN = RESET_PULSE_CYCLES;
  localparam int LP_MAX = LOW_POWER_CYCLES;
  localparam int SEL_MAX = MODSEL_CYCLES;
  logic [5:0] low_cnt;
  logic [INIT_W:0] nr_cnt;

  always_ff @(posedge CORE_CLK or negedge rst_sync) begin
    if (!rst_sync) begin
      low_cnt <= '0;
      nr_cnt <= '0;
    end else begin
      low_cnt <= mod_rst_n_s ? '0 :
        ((low_cnt == '1) ? low_cnt : low_cnt + 6'h01);
      nr_cnt <= (s.in_reset || !s.not_ready) ? '0 :
        nr_cnt + (INIT_W + 1)'(1);
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!rst_sync);

  init_bound_a: assert property (
    nr_cnt <= (INIT_W + 1)'(INIT_CYCLES))
    else $error("data not ready held past the init deadline");
  ready_irq_a: assert property ($fell(s.not_ready) |-> !INTERRUPT_N)
    else $error("ready did not assert the interrupt");
  hold_ready_a: assert property ((s.not_ready && !s.data_valid &&
    !init_done) |=> s.not_ready)
    else $error("data not ready cleared before data valid");
  reset_pulse_a: assert property ($rose(s.in_reset) |->
    low_cnt > 6'(RST_MIN))
    else $error("module reset taken on a short pulse");
  lp_pin_a: assert property (lp_s |-> ##[1:LP_MAX] LOW_POWER_MODE)
    else $error("low power pin not honoured in time");
  desel_a: assert property ($rose(sel_n_s) |-> ##[1:SEL_MAX]
    (s.st == I2C_IDLE && !SDA_OE))
    else $error("bus still answered after deselect");
  flag_set_a: assert property ((|s.cond && !s.in_reset) |=>
    ((s.flags & $past(s.cond)) == $past(s.cond)))
    else $error("flag not set by its condition");
  irq_mask_a: assert property (((s.flags & ~s.mask) == '0 &&
    !s.ready_evt) |-> INTERRUPT_N)
    else $error("masked flag drove the interrupt");
  irq_unmask_a: assert property (
    |(s.flags & ~s.mask) |-> !INTERRUPT_N)
    else $error("unmasked flag did not drive the interrupt");
  mask_stop_a: assert property ($changed(s.mask) |->
    ($past(stop_ev) || $past(s.in_reset)))
    else $error("mask changed outside a stop");
  pdown_a: assert property (s.pdown |-> LOW_POWER_MODE)
    else $error("power down bit without low power");
  addr_ack_a: assert property ($rose(s.st == I2C_ADDR_ACK) |->
    ($past(s.shift[7:1]) == DEV_ADDR && SDA_OE))
    else $error("acknowledged a foreign device address");

  ready_c: cover property ($fell(s.not_ready));
  read_clear_c: cover property (stop_ev && active && s.pend_clr != '0);
  mask_write_c: cover property (stop_ev && active && s.pend_mask_v);
  reset_c: cover property ($rose(s.in_reset));
endmodule : mgmt_ctrl

// ---- logic/mgmt_pkg.sv ----
// constants for the transceiver management control block
// assumes a 10 MHz core clock and a host on the 2-wire management bus
package mgmt_pkg;
  // core clock
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 100;

  // times as specified, and the cycle counts derived from them
  localparam int T_INIT_MS = 2000;
  localparam int INIT_CYCLES = T_INIT_MS * (CLK_HZ / 1000);
  localparam int T_RESET_PULSE_NS = 2000;
  localparam int RESET_PULSE_CYCLES =
    (T_RESET_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_LOW_POWER_US = 100;
  localparam int LOW_POWER_CYCLES = T_LOW_POWER_US * 1000 / CLK_NS;
  localparam int T_MODSEL_US = 100;
  localparam int MODSEL_CYCLES = T_MODSEL_US * 1000 / CLK_NS;

  // timer widths
  localparam int INIT_W = 25;
  localparam int PULSE_W = 5;

  // 2-wire bus: device address A0h in 8-bit form
  localparam logic [6:0] DEV_ADDR = 7'h50;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [7:0] PAGE_STATUS = 8'h02;
  localparam logic [7:0] PAGE_FLAGS = 8'h03;
  localparam logic [7:0] PAGE_CTRL = 8'h5D;
  localparam logic [7:0] PAGE_MASK = 8'h64;
  localparam int NOT_READY_BIT = 0;
  localparam int PDOWN_BIT = 0;

  // wishbone register byte addresses
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] WB_COND = 4'h0;
  localparam logic [ADR_W-1:0] WB_CTRL = 4'h4;
  localparam logic [ADR_W-1:0] WB_STATUS = 4'h8;

  // 2-wire slave states
  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_WDATA, I2C_WACK, I2C_RDATA,
    I2C_RACK
  } i2c_state_t;
endpackage : mgmt_pkg

// ---- tb/mgmt_ctrl_tb.sv ----
// self-checking bench for the management control block
// assumes the host model in mgmt_host and a 10 MHz core clock
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      num_errors++; \
      $display("CHECK FAILED %0t: got %h want %h", $time, g, e); \
    end \
  end
module mgmt_ctrl_tb;
  import mgmt_pkg::*;
  localparam int INIT_N = 200; // short init keeps the run brief
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mod_rst_n = 1'b1;
  logic sel_n = 1'b0;
  logic lp_req = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat, obs, e, wb_rd;
  logic scl, host_oe, sda, int_n, lpm, sda_oe, sda_out, ack;
  logic [31:0] exp_q[$];
  int num_errors = 0;
  int checks_done = 0;
  integer seed = 38;
  event obs_ev;
  // pulled-up open-drain wire; the module drives its output level when enabled
  assign sda = ~host_oe & (sda_oe ? sda_out : 1'b1);
  always #50 clk = ~clk;
  mgmt_ctrl #(.INIT_CYCLES(INIT_N)) u_mgmt_ctrl (
    .CORE_CLK(clk), .RST_N(rst_n), .MODULE_RESET_N(mod_rst_n),
    .MODULE_SELECT_N(sel_n), .LOW_POWER_REQUEST(lp_req),
    .MODULE_PRESENT_N(), .INTERRUPT_N(int_n), .LOW_POWER_MODE(lpm),
    .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(rdat), .WB_ACK_O(ack));
  mgmt_host u_mgmt_host (.scl(scl), .host_oe(host_oe), .sda(sda));
  task automatic end_of_test;
    if (exp_q.size() != 0) num_errors++;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic expect_v(input logic [31:0] v);
    exp_q.push_back(v);
  endtask : expect_v
  // the short pause keeps two results from sharing one time step
  task automatic got(input logic [31:0] v);
    obs = v;
    -> obs_ev;
    #1;
  endtask : got
  // scoreboard: each result is matched to the oldest expectation
  always @(obs_ev) begin
    if (exp_q.size() == 0) begin
      num_errors++;
      $display("CHECK FAILED %0t: result without expectation", $time);
    end else begin
      e = exp_q.pop_front();
      `CHK(obs, e)
    end
  end
  // classic single wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [ADR_W-1:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    // no cycle count assumed: only the watchdog ends a stuck wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic chk_wb(input logic [ADR_W-1:0] a, input logic [31:0] m,
                        input logic [31:0] x);
    logic [31:0] q;
    expect_v(x);
    wb(1'b0, a, 32'h0, q);
    got(q & m);
  endtask : chk_wb
  // x holds the address ack above the read byte
  task automatic chk_rd(input logic [7:0] p, input logic [8:0] x);
    logic [7:0] d;
    logic a;
    expect_v({23'h0, x});
    u_mgmt_host.read(p, d, a);
    got({23'h0, a, d});
  endtask : chk_rd
  task automatic wr2(input logic [7:0] p, input logic [7:0] d);
    logic a;
    expect_v(32'h1);
    u_mgmt_host.write(p, d, a);
    got({31'h0, a});
  endtask : wr2
  // waits a bounded time for interrupt (s=0) or low power (s=1)
  task automatic wait_pin(input int s, input logic v, input int n);
    logic p;
    expect_v({31'h0, v});
    repeat (n) begin
      @(negedge clk);
      p = s ? lpm : int_n;
      if (p === v) break;
    end
    got({31'h0, p});
  endtask : wait_pin
  // main sequence
  initial begin
    logic [7:0] v;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk_wb(WB_STATUS, 32'h3, 32'h3);
    wait_pin(0, 1'b0, INIT_N + 50);
    chk_wb(WB_STATUS, 32'h1, 32'h0);
    chk_rd(PAGE_STATUS, 9'h100);
    wait_pin(0, 1'b1, 10);
    wb(1'b1, 4'hC, 32'hFF, wb_rd);
    chk_wb(4'hC, 32'hFFFFFFFF, 32'h0);
    // random live conditions raise flags and the interrupt
    v = 8'($random(seed)) | 8'h01;
    wb(1'b1, WB_COND, {24'h0, v}, wb_rd);
    wait_pin(0, 1'b0, 10);
    wb(1'b1, WB_COND, 32'h0, wb_rd);
    chk_wb(WB_STATUS, 32'hFF00, {16'h0, v, 8'h0});
    chk_rd(PAGE_FLAGS, {1'b1, v});
    wait_pin(0, 1'b1, 10);
    // masked flag still latches but stays off the interrupt
    wr2(PAGE_MASK, 8'hFF);
    wb(1'b1, WB_COND, 32'h10, wb_rd);
    wb(1'b1, WB_COND, 32'h0, wb_rd);
    chk_wb(WB_STATUS, 32'hFF02, 32'h1002);
    wr2(PAGE_MASK, 8'h00);
    wait_pin(0, 1'b0, 10);
    chk_rd(PAGE_FLAGS, 9'h110);
    wait_pin(0, 1'b1, 10);
    @(posedge clk);
    lp_req <= 1'b1;
    wait_pin(1, 1'b1, 10);
    @(posedge clk);
    lp_req <= 1'b0;
    wait_pin(1, 1'b0, 10);
    wr2(PAGE_CTRL, 8'h01);
    wait_pin(1, 1'b1, 10);
    wr2(PAGE_CTRL, 8'h00);
    wait_pin(1, 1'b0, 10);
    // deselected module ignores the bus
    @(posedge clk);
    sel_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk_rd(PAGE_STATUS, 9'h000);
    @(posedge clk);
    sel_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk_rd(PAGE_STATUS, 9'h100);
    // 1 us reset pulse is ignored, 4 us pulse resets
    @(posedge clk);
    mod_rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    mod_rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk_wb(WB_STATUS, 32'h21, 32'h0);
    @(posedge clk);
    mod_rst_n <= 1'b0;
    repeat (40) @(posedge clk);
    chk_wb(WB_STATUS, 32'h20, 32'h20);
    @(posedge clk);
    mod_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk_wb(WB_STATUS, 32'h21, 32'h01);
    // firmware marks monitor data valid long before the init deadline
    wb(1'b1, WB_CTRL, 32'h1, wb_rd);
    chk_wb(WB_CTRL, 32'hFFFFFFFF, 32'h1);
    wait_pin(0, 1'b0, 10);
    end_of_test();
  end
  // watchdog: the sequence needs well under 2 ms
  initial begin
    #2_000_000;
    num_errors++;
    end_of_test();
  end
endmodule : mgmt_ctrl_tb

// ---- tb/mgmt_host.sv ----
// host model on the 2-wire bus: drives the clock, pulls data low
// assumes the bench resolves the pulled-up data wire from both enables
`timescale 1ns/1ps
module mgmt_host (
  // bus wires
  output logic scl,
  output logic host_oe,
  input wire logic sda
);
  localparam time Q = 200; // quarter of the 800 ns bus period
  // clock stands high and data released between frames
  initial begin
    scl = 1'b1;
    host_oe = 1'b0;
  end
  // data moves only while the clock is low
  task automatic wbit(input logic b);
    host_oe = ~b;
    #Q scl = 1'b1;
    #(2*Q) scl = 1'b0;
    #Q;
  endtask : wbit
  task automatic rbit(output logic b);
    host_oe = 1'b0;
    #Q scl = 1'b1;
    #Q b = sda;
    #Q scl = 1'b0;
    #Q;
  endtask : rbit
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(a);
    ack = ~a;
  endtask : wbyte
  // single-byte read, so the host always answers with a nack
  task automatic rbyte(output logic [7:0] d);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(1'b1);
  endtask : rbyte
  // odd offset keeps bus edges away from core clock edges
  task automatic start();
    #37 host_oe = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : start
  task automatic stop();
    host_oe = 1'b1;
    #Q scl = 1'b1;
    #Q host_oe = 1'b0;
    #Q;
  endtask : stop
  task automatic write(input logic [7:0] p, input logic [7:0] d,
                       output logic ack);
    logic a;
    start();
    wbyte(8'hA0, ack);
    if (ack) begin
      wbyte(p, a);
      wbyte(d, a);
    end
    stop();
  endtask : write
  // pointer set in its own frame, then a plain read frame
  task automatic read(input logic [7:0] p, output logic [7:0] d,
                      output logic ack);
    logic a;
    d = 8'h00;
    start();
    wbyte(8'hA0, ack);
    if (ack) wbyte(p, a);
    stop();
    if (ack) begin
      start();
      wbyte(8'hA1, a);
      rbyte(d);
      stop();
    end
  endtask : read
endmodule : mgmt_host
